// ===== hps_link_if.sv
// byte register link between pattern host and pattern store device
// assumes both ends share one clock; read data stand one cycle after strobe
`timescale 1ns/1ps
interface hps_link_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;

  modport dev (input addr, input wdata, input wr, input rd, output rdata);
  modport host (output addr, output wdata, output wr, output rd,
    input rdata);
endinterface

// ===== hps_link_props.sv
// checker for the byte link and the drive outputs of the pattern store
// assumes one clock domain; instantiated beside the link in the bench
`timescale 1ns/1ps
module hps_link_props
  import hps_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic trig_i,
  input wire logic drive_en_o,
  input wire logic drive_neg_o,
  input wire logic [6:0] drive_amp_o,
  input wire logic brake_o,
  input wire logic busy_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);

  // middle then low read strobes of one word readback
  sequence s_rd_tail;
    rd && addr == HPS_REG_DATA_M ##1 rd && addr == HPS_REG_DATA_L;
  endsequence
  // a trigger edge that the idle engine must take
  sequence s_start;
    $rose(trig_i) && !busy_o;
  endsequence

  // link handshake order
  chk_strobe_excl: assert property (!(wr && rd))
    else $error("both strobes high");
  chk_enable_first: assert property (wr && addr == HPS_REG_PTR |->
    $past(wr) && $past(addr) == HPS_REG_CTRL && $past(wdata[6]))
    else $error("pointer write without enable");
  chk_ptr_then_high: assert property (wr && addr == HPS_REG_DATA_H |->
    $past(wr) && $past(addr) == HPS_REG_PTR)
    else $error("high byte not after pointer");
  chk_low_after_mid: assert property (wr && addr == HPS_REG_DATA_L |->
    $past(wr) && $past(addr) == HPS_REG_DATA_M)
    else $error("low byte not after middle");
  chk_read_order: assert property (rd && addr == HPS_REG_DATA_H |=>
    s_rd_tail)
    else $error("readback bytes out of order");
  chk_rdata_zero: assert property (!$past(rd) |->
    rdata == HPS_BYTE_ZERO)
    else $error("read data outside its cycle");

  // playback timing and output shape
  chk_trig_busy: assert property (s_start |=> busy_o)
    else $error("trigger did not start playback");
  chk_trig_drive: assert property (s_start |-> ##[3:4] drive_en_o)
    else $error("no drive after trigger");
  // four cycles is one step with the bench step setting
  chk_drive_min: assert property ($rose(drive_en_o) |->
    drive_en_o[*4])
    else $error("drive shorter than a step");
  chk_amp_gated: assert property (!drive_en_o |->
    drive_amp_o == 7'h00 && !drive_neg_o)
    else $error("level without drive");
  chk_brake_zero: assert property (brake_o |->
    !drive_en_o && drive_amp_o == 7'h00)
    else $error("brake overlaps drive");
  chk_idle_quiet: assert property (!busy_o && !$past(busy_o) |->
    !drive_en_o && !brake_o)
    else $error("output after playback end");
endmodule // hps_link_props

// ===== hps_pattern_dev.sv
// haptic pattern store: 256 x 24-bit sample memory and its playback engine
// assumes a host on hps_link_if issuing one-cycle byte strobes
//
// How it works
// RQ1: host enables memory access before any access
// RQ2: pointer write, then high/middle/low stored together
// RQ3: readback: pointer, then read high, middle, low
// RQ4: high byte: link, sign, amplitude 6:2
// RQ5: middle byte: amplitude 1:0, duration, wait 4
// RQ6: low byte: wait 3:0, repeat count
// RQ7: link code selects last, more, interpolate, loop
// RQ8: sign zero positive, one negative drive
// RQ9: seven-bit amplitude of full scale, plus direction
// RQ10: drive lasts duration times 5 ms
// RQ11: then zero for wait times 5 ms
// RQ12: repeat count repeats sample or whole pattern
// RQ13: last sample, no repeat: brake for wait
// RQ14: host stores first sample with positive sign
// RQ15: host encodes braking samples as negative; the host writes sample words unchanged apart from the RQ14 sign clear
// RQ16: 256 words of 24 bits, 8-bit pointer
// RQ17: playback starts at pattern start location
// RQ18: trigger starts the stored pattern
// RQ19: middle byte: amp 7:6, dur 5:1, wait 0
// RQ20: after last sample output zero, stop fetching
`timescale 1ns/1ps
module hps_pattern_dev
  import hps_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = HPS_STEP_CYCLES
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  hps_link_if.dev bus,
  input wire logic trig_i,
  output logic drive_en_o,
  output logic drive_neg_o,
  output logic [6:0] drive_amp_o,
  output logic brake_o,
  output logic busy_o
);

  typedef struct packed {
    logic pattern_memory_access_enable;
    logic trig_bit;
    logic [7:0] pattern_start_location;
    logic [7:0] pattern_memory_pointer;
    logic [7:0] pattern_data_high_byte;
    logic [7:0] pattern_data_middle_byte;
    hps_sample_s rd_word;
    logic [7:0] rdata;
    logic trig_in;
    hps_play_e st;
    logic [7:0] addr;
    hps_sample_s cur;
    logic signed [7:0] lvl;
    logic signed [7:0] nxt_lvl;
    logic [4:0] steps;
    logic [HPS_CYC_W-1:0] cyc;
    logic [3:0] rep;
    logic [3:0] pat_rep;
    logic out_en;
    logic out_neg;
    logic [6:0] out_amp;
    logic out_brk;
  } hps_dev_state_s;

  localparam logic [HPS_CYC_W-1:0] STEP_LAST = HPS_CYC_W'(STEP_CYCLES - 1);

  hps_dev_state_s q, d;
  logic [23:0] ram [HPS_DEPTH]; // RQ16
  logic ram_we;
  logic [23:0] ram_wdata;
  hps_sample_s ptr_word;
  hps_sample_s play_word;
  hps_sample_s next_word;

  // memory read ports: pointer side for readback, play side for fetch
  assign ptr_word = hps_sample_s'(ram[q.pattern_memory_pointer]);
  assign play_word = hps_sample_s'(ram[q.addr]);
  assign next_word = hps_sample_s'(ram[8'(q.addr + 8'h01)]);

  // low byte write commits the whole word at once, never a torn word
  assign ram_we = bus.wr && bus.addr == HPS_REG_DATA_L &&
    q.pattern_memory_access_enable; // RQ1
  assign ram_wdata = {q.pattern_data_high_byte, q.pattern_data_middle_byte,
    bus.wdata}; // RQ2 RQ4 RQ5 RQ6 RQ19

  // sample memory has no reset; contents are undefined until loaded
  always_ff @(posedge mclk_i)
  begin
    if (ram_we)
      ram[q.pattern_memory_pointer] <= ram_wdata; // RQ2
  end

  always_comb
  begin
    logic tick;
    logic trig_ev;
    logic advance;
    logic signed [7:0] abs_lvl;
    tick = 1'b0;
    trig_ev = 1'b0;
    advance = 1'b0;
    abs_lvl = '0;
    d = q;
    d.rdata = HPS_BYTE_ZERO;
    d.trig_in = trig_i;

    // register writes
    if (bus.wr)
    begin
      unique case (bus.addr)
        HPS_REG_CTRL:
        begin
          d.pattern_memory_access_enable = |(bus.wdata & HPS_CTRL_MEM_EN);
          d.trig_bit = |(bus.wdata & HPS_CTRL_TRIG);
          trig_ev = |(bus.wdata & HPS_CTRL_TRIG) && !q.trig_bit; // RQ18
        end
        HPS_REG_START: d.pattern_start_location = bus.wdata; // RQ17
        HPS_REG_PTR: d.pattern_memory_pointer = bus.wdata; // RQ2
        HPS_REG_DATA_H:
          if (q.pattern_memory_access_enable)
            d.pattern_data_high_byte = bus.wdata; // RQ2
        HPS_REG_DATA_M:
          if (q.pattern_memory_access_enable)
            d.pattern_data_middle_byte = bus.wdata; // RQ2
        default: ;
      endcase
    end

    // register reads: data stand in the next cycle only
    if (bus.rd)
    begin
      unique case (bus.addr)
        HPS_REG_CTRL:
          d.rdata = (q.trig_bit ? HPS_CTRL_TRIG : HPS_BYTE_ZERO) |
            (q.pattern_memory_access_enable ? HPS_CTRL_MEM_EN : HPS_BYTE_ZERO);
        HPS_REG_START: d.rdata = q.pattern_start_location;
        HPS_REG_PTR: d.rdata = q.pattern_memory_pointer;
        HPS_REG_DATA_H:
          if (q.pattern_memory_access_enable)
          begin
            // snapshot whole word so middle and low match this high byte
            d.rd_word = ptr_word; // RQ3
            d.rdata = ptr_word[HPS_BYTE_H_LSB +: 8];
          end
        HPS_REG_DATA_M:
          if (q.pattern_memory_access_enable)
            d.rdata = q.rd_word[HPS_BYTE_M_LSB +: 8]; // RQ3
        HPS_REG_DATA_L:
          if (q.pattern_memory_access_enable)
            d.rdata = q.rd_word[HPS_BYTE_L_LSB +: 8]; // RQ3
        HPS_REG_PLAY_STAT:
          d.rdata = (q.st != PLAY_IDLE) ? HPS_STAT_BUSY : HPS_BYTE_ZERO;
        default: ;
      endcase
    end

    // rising edge of pin or control bit starts playback
    if (trig_i && !q.trig_in)
      trig_ev = 1'b1; // RQ18

    // 5 ms step timer shared by drive, pause and brake phases
    if (q.st == PLAY_DRIVE || q.st == PLAY_PAUSE || q.st == PLAY_BRAKE)
    begin
      if (q.cyc == STEP_LAST)
      begin
        tick = 1'b1;
        d.cyc = '0;
      end
      else
        d.cyc = q.cyc + 1'b1;
    end

    unique case (q.st)
      PLAY_IDLE:
        if (trig_ev)
        begin
          d.addr = q.pattern_start_location; // RQ17
          d.pat_rep = '0;
          d.st = PLAY_FETCH;
        end
      PLAY_FETCH:
      begin
        d.cur = play_word;
        d.nxt_lvl = hps_level(next_word);
        d.rep = '0;
        d.st = PLAY_LOAD;
      end
      PLAY_LOAD:
      begin
        d.lvl = hps_level(q.cur); // RQ8 RQ9
        d.steps = q.cur.dur; // RQ10
        d.cyc = '0;
        d.st = PLAY_DRIVE;
      end
      PLAY_DRIVE:
        if (q.steps == HPS_STEPS_NONE)
        begin
          d.steps = {q.cur.wait_hi, q.cur.wait_lo}; // RQ11
          d.cyc = '0;
          if (q.cur.sample_link_code == HPS_LINK_LAST &&
            q.cur.repeat_count == HPS_RPT_NONE)
            d.st = PLAY_BRAKE; // RQ13
          else
            d.st = PLAY_PAUSE; // RQ11
        end
        else if (tick)
        begin
          d.steps = q.steps - 1'b1; // RQ10
          // ramp halfway toward the next sample on every step
          if (q.cur.sample_link_code == HPS_LINK_INTERP)
            d.lvl = hps_mid(q.lvl, q.nxt_lvl); // RQ7
        end
      PLAY_PAUSE, PLAY_BRAKE:
        if (q.steps == HPS_STEPS_NONE)
          advance = 1'b1;
        else if (tick)
          d.steps = q.steps - 1'b1; // RQ11 RQ13
      default: d.st = PLAY_IDLE;
    endcase

    // next sample, sample repeat or pattern repeat
    if (advance)
    begin
      if (q.cur.sample_link_code != HPS_LINK_LOOP &&
        q.rep < q.cur.repeat_count)
      begin
        d.rep = q.rep + 1'b1; // RQ12
        d.st = PLAY_LOAD;
      end
      else
      begin
        unique case (q.cur.sample_link_code)
          HPS_LINK_MORE, HPS_LINK_INTERP:
          begin
            d.addr = q.addr + 1'b1; // RQ7
            d.st = PLAY_FETCH;
          end
          HPS_LINK_LOOP:
            if (q.pat_rep < q.cur.repeat_count)
            begin
              d.pat_rep = q.pat_rep + 1'b1; // RQ12
              d.addr = q.pattern_start_location;
              d.st = PLAY_FETCH;
            end
            else
              d.st = PLAY_IDLE; // RQ20
          HPS_LINK_LAST: d.st = PLAY_IDLE; // RQ20
        endcase
      end
    end

    // registered drive outputs; zero level outside the drive phase
    abs_lvl = d.lvl[7] ? -d.lvl : d.lvl;
    d.out_en = d.st == PLAY_DRIVE;
    d.out_neg = d.out_en && d.lvl[7]; // RQ8
    d.out_amp = d.out_en ? abs_lvl[6:0] : 7'h00; // RQ9 RQ20
    d.out_brk = d.st == PLAY_BRAKE; // RQ13
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      q <= '0;
      q.st <= PLAY_IDLE;
    end
    else
      q <= d;
  end

  assign bus.rdata = q.rdata;
  assign drive_en_o = q.out_en;
  assign drive_neg_o = q.out_neg;
  assign drive_amp_o = q.out_amp;
  assign brake_o = q.out_brk;
  assign busy_o = q.st != PLAY_IDLE;

endmodule // hps_pattern_dev

// ===== hps_pattern_host.sv
// host end: turns software commands into byte register sequences
// assumes the pattern store answers reads one cycle after the strobe
`timescale 1ns/1ps
module hps_pattern_host
  import hps_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  hps_link_if.host bus,
  input wire logic [7:0] sw_addr_i,
  input wire logic [7:0] sw_wdata_i,
  input wire logic sw_wr_i,
  input wire logic sw_rd_i,
  output logic [7:0] sw_rdata_o
);

  typedef struct packed {
    hps_host_e st;
    logic op_read;
    logic op_trig;
    logic op_start;
    logic [7:0] ptr;
    logic [7:0] start;
    logic [7:0] word_h;
    logic [7:0] word_m;
    logic [7:0] word_l;
    logic [7:0] sw_rdata;
    logic [7:0] bus_addr;
    logic [7:0] bus_wdata;
    logic bus_wr;
    logic bus_rd;
    logic rd_seen;
    logic [7:0] rd_addr_seen;
  } hps_host_state_s;

  hps_host_state_s q, d;

  always_comb
  begin
    logic busy;
    busy = q.st != HOST_IDLE;
    d = q;
    d.sw_rdata = HPS_BYTE_ZERO;
    d.bus_wr = 1'b0;
    d.bus_rd = 1'b0;
    d.rd_seen = q.bus_rd;
    d.rd_addr_seen = q.bus_addr;

    // software writes; commands and data are ignored while busy
    if (sw_wr_i && !busy)
    begin
      unique case (sw_addr_i)
        HPS_HOST_CMD:
          if (|sw_wdata_i[HPS_CMD_START:HPS_CMD_WRITE])
          begin
            d.op_read = sw_wdata_i[HPS_CMD_READ];
            d.op_trig = sw_wdata_i[HPS_CMD_TRIG];
            d.op_start = sw_wdata_i[HPS_CMD_START];
            d.st = HOST_EN;
          end
        HPS_HOST_PTR: d.ptr = sw_wdata_i;
        HPS_HOST_WORD_H: d.word_h = sw_wdata_i;
        HPS_HOST_WORD_M: d.word_m = sw_wdata_i;
        HPS_HOST_WORD_L: d.word_l = sw_wdata_i;
        HPS_HOST_START: d.start = sw_wdata_i;
        default: ;
      endcase
    end

    // software reads, answered in the next cycle
    if (sw_rd_i)
    begin
      unique case (sw_addr_i)
        HPS_HOST_PTR: d.sw_rdata = q.ptr;
        HPS_HOST_WORD_H: d.sw_rdata = q.word_h;
        HPS_HOST_WORD_M: d.sw_rdata = q.word_m;
        HPS_HOST_WORD_L: d.sw_rdata = q.word_l;
        HPS_HOST_STAT: d.sw_rdata = busy ? HPS_STAT_BUSY : HPS_BYTE_ZERO;
        HPS_HOST_START: d.sw_rdata = q.start;
        default: ;
      endcase
    end

    // capture readback bytes as they return from the device
    if (q.rd_seen)
    begin
      unique case (q.rd_addr_seen)
        HPS_REG_DATA_H: d.word_h = bus.rdata; // RQ3
        HPS_REG_DATA_M: d.word_m = bus.rdata; // RQ3
        HPS_REG_DATA_L: d.word_l = bus.rdata; // RQ3
        default: ;
      endcase
    end

    // at most one register strobe per state, issued from flip-flops
    unique case (q.st)
      HOST_IDLE: ;
      HOST_EN:
      begin
        d.bus_wr = 1'b1;
        d.bus_addr = HPS_REG_CTRL;
        d.bus_wdata = HPS_CTRL_MEM_EN; // RQ1
        if (q.op_start)
          d.st = HOST_START;
        else if (q.op_trig)
          d.st = HOST_TRIG_SET;
        else
          d.st = HOST_PTR;
      end
      HOST_PTR:
      begin
        d.bus_wr = 1'b1;
        d.bus_addr = HPS_REG_PTR; // RQ2
        d.bus_wdata = q.ptr;
        d.st = q.op_read ? HOST_RH : HOST_WH;
      end
      HOST_WH:
      begin
        d.bus_wr = 1'b1;
        d.bus_addr = HPS_REG_DATA_H;
        // a pattern's first sample always starts its drive positive
        d.bus_wdata = (q.ptr == q.start) ? (q.word_h & ~HPS_HIGH_SIGN) :
          q.word_h; // RQ14
        d.st = HOST_WM;
      end
      HOST_WM:
      begin
        d.bus_wr = 1'b1;
        d.bus_addr = HPS_REG_DATA_M;
        d.bus_wdata = q.word_m;
        d.st = HOST_WL;
      end
      HOST_WL:
      begin
        d.bus_wr = 1'b1;
        d.bus_addr = HPS_REG_DATA_L; // RQ2
        d.bus_wdata = q.word_l;
        d.st = HOST_IDLE;
      end
      HOST_RH:
      begin
        d.bus_rd = 1'b1;
        d.bus_addr = HPS_REG_DATA_H; // RQ3
        d.st = HOST_RM;
      end
      HOST_RM:
      begin
        d.bus_rd = 1'b1;
        d.bus_addr = HPS_REG_DATA_M;
        d.st = HOST_RL;
      end
      HOST_RL:
      begin
        d.bus_rd = 1'b1;
        d.bus_addr = HPS_REG_DATA_L;
        d.st = HOST_RW1;
      end
      // stay busy until the low byte has landed
      HOST_RW1: d.st = HOST_RW2;
      HOST_RW2: d.st = HOST_IDLE;
      HOST_START:
      begin
        d.bus_wr = 1'b1;
        d.bus_addr = HPS_REG_START;
        d.bus_wdata = q.start;
        d.st = q.op_trig ? HOST_TRIG_SET : HOST_IDLE;
      end
      HOST_TRIG_SET:
      begin
        d.bus_wr = 1'b1;
        d.bus_addr = HPS_REG_CTRL;
        d.bus_wdata = HPS_CTRL_MEM_EN | HPS_CTRL_TRIG;
        d.st = HOST_TRIG_CLR;
      end
      HOST_TRIG_CLR:
      begin
        // drop the bit so the next trigger is a fresh 0-to-1 edge
        d.bus_wr = 1'b1;
        d.bus_addr = HPS_REG_CTRL;
        d.bus_wdata = HPS_CTRL_MEM_EN;
        d.st = HOST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      q <= '0;
      q.st <= HOST_IDLE;
    end
    else
      q <= d;
  end

  assign bus.addr = q.bus_addr;
  assign bus.wdata = q.bus_wdata;
  assign bus.wr = q.bus_wr;
  assign bus.rd = q.bus_rd;
  assign sw_rdata_o = q.sw_rdata;

endmodule // hps_pattern_host

// ===== hps_pkg.sv
// shared constants and types for the haptic pattern store and its host
// assumes byte-wide register access, one clock at 125 MHz
package hps_pkg;

  // device register offsets on the byte register link
  localparam logic [7:0] HPS_REG_CTRL = 8'h09;
  localparam logic [7:0] HPS_REG_START = 8'h0b;
  localparam logic [7:0] HPS_REG_PTR = 8'h40;
  localparam logic [7:0] HPS_REG_DATA_H = 8'h41;
  localparam logic [7:0] HPS_REG_DATA_M = 8'h42;
  localparam logic [7:0] HPS_REG_DATA_L = 8'h43;
  localparam logic [7:0] HPS_REG_PLAY_STAT = 8'h44;

  // control, status and sample high byte fields
  localparam logic [7:0] HPS_CTRL_TRIG = 8'h80;
  localparam logic [7:0] HPS_CTRL_MEM_EN = 8'h40;
  localparam logic [7:0] HPS_HIGH_SIGN = 8'h20;
  localparam logic [7:0] HPS_STAT_BUSY = 8'h01;
  localparam logic [7:0] HPS_BYTE_ZERO = 8'h00;

  // host command port offsets
  localparam logic [7:0] HPS_HOST_CMD = 8'h00;
  localparam logic [7:0] HPS_HOST_PTR = 8'h01;
  localparam logic [7:0] HPS_HOST_WORD_H = 8'h02;
  localparam logic [7:0] HPS_HOST_WORD_M = 8'h03;
  localparam logic [7:0] HPS_HOST_WORD_L = 8'h04;
  localparam logic [7:0] HPS_HOST_STAT = 8'h05;
  localparam logic [7:0] HPS_HOST_START = 8'h06;
  localparam int HPS_CMD_WRITE = 0;
  localparam int HPS_CMD_READ = 1;
  localparam int HPS_CMD_TRIG = 2;
  localparam int HPS_CMD_START = 3;

  // memory geometry and byte positions inside a word
  localparam int HPS_DEPTH = 256;
  localparam int HPS_BYTE_H_LSB = 16;
  localparam int HPS_BYTE_M_LSB = 8;
  localparam int HPS_BYTE_L_LSB = 0;

  // sample link codes
  localparam logic [1:0] HPS_LINK_LAST = 2'h0;
  localparam logic [1:0] HPS_LINK_MORE = 2'h1;
  localparam logic [1:0] HPS_LINK_INTERP = 2'h2;
  localparam logic [1:0] HPS_LINK_LOOP = 2'h3;
  localparam logic [3:0] HPS_RPT_NONE = 4'h0;
  localparam logic [4:0] HPS_STEPS_NONE = 5'h00;

  // timing: one duration step is 5 ms
  localparam int HPS_STEP_MS = 5;
  localparam int HPS_CLK_NS = 8;
  localparam int HPS_STEP_CYCLES = HPS_STEP_MS * 1000000 / HPS_CLK_NS;
  localparam int HPS_CYC_W = 20;

  // one stored sample, high byte first
  typedef struct packed {
    logic [1:0] sample_link_code;
    logic amplitude_sign;
    logic [4:0] amp_hi;
    logic [1:0] amp_lo;
    logic [4:0] dur;
    logic wait_hi;
    logic [3:0] wait_lo;
    logic [3:0] repeat_count;
  } hps_sample_s;

  typedef enum logic [2:0] {
    PLAY_IDLE, PLAY_FETCH, PLAY_LOAD, PLAY_DRIVE, PLAY_PAUSE, PLAY_BRAKE
  } hps_play_e;

  typedef enum logic [3:0] {
    HOST_IDLE, HOST_EN, HOST_PTR, HOST_WH, HOST_WM, HOST_WL, HOST_RH,
    HOST_RM, HOST_RL, HOST_RW1, HOST_RW2, HOST_START, HOST_TRIG_SET,
    HOST_TRIG_CLR
  } hps_host_e;

  // signed drive level of a sample: magnitude with direction
  function automatic logic signed [7:0] hps_level(input hps_sample_s s);
    logic signed [7:0] mag;
    mag = {1'b0, s.amp_hi, s.amp_lo};
    return s.amplitude_sign ? -mag : mag;
  endfunction

  // halfway step from one level toward another
  function automatic logic signed [7:0] hps_mid(
    input logic signed [7:0] a,
    input logic signed [7:0] b
  );
    logic signed [8:0] sum;
    sum = {a[7], a} + {b[7], b};
    return sum[8:1];
  endfunction

endpackage

// ===== tb_haptic_pattern_ram_store.sv
// self-checking bench: host and pattern store joined by the byte link
// assumes step parameter 4, so one 5 ms step lasts four clocks
`timescale 1ns/1ps
module tb_haptic_pattern_ram_store;
  import hps_pkg::*;
  localparam int S = 4;
  localparam logic [7:0] ST = 8'h10;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic trig_i = 1'b0;
  logic [7:0] sw_addr_i = 8'h00;
  logic [7:0] sw_wdata_i = 8'h00;
  logic sw_wr_i = 1'b0;
  logic sw_rd_i = 1'b0;
  logic [7:0] sw_rdata_o;
  logic drive_en_o, drive_neg_o, brake_o, busy_o;
  logic [6:0] drive_amp_o;
  logic [31:0] seed = 32'h03cffdce;
  logic [23:0] mem [256];
  logic [7:0] ptrs [12];
  logic [23:0] w;
  int fail_count = 0;
  int samples_checked = 0;
  int n1, n2, nb, no;

  hps_link_if hps_link_if_inst ();
  hps_pattern_dev #(.STEP_CYCLES(S)) hps_pattern_dev_inst (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .bus(hps_link_if_inst),
    .trig_i(trig_i), .drive_en_o(drive_en_o), .drive_neg_o(drive_neg_o),
    .drive_amp_o(drive_amp_o), .brake_o(brake_o), .busy_o(busy_o));
  hps_pattern_host hps_pattern_host_inst (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .bus(hps_link_if_inst),
    .sw_addr_i(sw_addr_i), .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i),
    .sw_rd_i(sw_rd_i), .sw_rdata_o(sw_rdata_o));
  hps_link_props hps_link_props_inst (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .addr(hps_link_if_inst.addr), .wdata(hps_link_if_inst.wdata),
    .wr(hps_link_if_inst.wr), .rd(hps_link_if_inst.rd),
    .rdata(hps_link_if_inst.rdata), .trig_i(trig_i),
    .drive_en_o(drive_en_o), .drive_neg_o(drive_neg_o),
    .drive_amp_o(drive_amp_o), .brake_o(brake_o), .busy_o(busy_o));

  // clock and watchdog; the run needs under a thousand cycles
  initial
  begin
    forever #4 mclk_i = ~mclk_i;
  end
  initial
  begin
    repeat (60000) @(posedge mclk_i);
    fail_count++;
    give_verdict();
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  // the host forces the first sample of a pattern positive
  function automatic logic [23:0] stored(input logic [7:0] p,
    input logic [23:0] v);
    return (p == ST) ? (v & ~24'h200000) : v;
  endfunction
  function automatic logic [23:0] mk(input logic [1:0] lk,
    input logic sg, input logic [6:0] a, input logic [4:0] d,
    input logic [4:0] wt, input logic [3:0] r);
    return {lk, sg, a[6:2], a[1:0], d, wt[4], wt[3:0], r};
  endfunction

  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check_val(input string n, input logic [23:0] e,
    input logic [23:0] s);
    samples_checked++;
    if (s !== e)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic check_range(input string n, input int lo, input int hi,
    input int s);
    samples_checked++;
    if (s < lo || s > hi)
    begin
      fail_count++;
      $display("Error %s expected %0d to %0d seen %0d", n, lo, hi, s);
    end
  endtask

  // software port cycles: one-cycle strobes set just after an edge
  task automatic sw_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    sw_addr_i <= a;
    sw_wdata_i <= d;
    sw_wr_i <= 1'b1;
    @(posedge mclk_i);
    sw_wr_i <= 1'b0;
  endtask
  task automatic sw_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    sw_addr_i <= a;
    sw_rd_i <= 1'b1;
    @(posedge mclk_i);
    sw_rd_i <= 1'b0;
    #1;
    d = sw_rdata_o;
  endtask
  // bounded poll of the host busy flag
  task automatic wait_idle();
    logic [7:0] s;
    s = 8'h01;
    for (int i = 0; i < 40 && s[0] !== 1'b0; i++)
      sw_read(HPS_HOST_STAT, s);
    if (s[0] !== 1'b0)
    begin
      fail_count++;
      give_verdict();
    end
  endtask
  task automatic put_word(input logic [7:0] p, input logic [23:0] v);
    sw_write(HPS_HOST_PTR, p);
    sw_write(HPS_HOST_WORD_H, v[23:16]);
    sw_write(HPS_HOST_WORD_M, v[15:8]);
    sw_write(HPS_HOST_WORD_L, v[7:0]);
    sw_write(HPS_HOST_CMD, 8'h01);
    wait_idle();
  endtask
  task automatic get_word(input logic [7:0] p, output logic [23:0] v);
    sw_write(HPS_HOST_PTR, p);
    sw_write(HPS_HOST_CMD, 8'h02);
    wait_idle();
    sw_read(HPS_HOST_WORD_H, v[23:16]);
    sw_read(HPS_HOST_WORD_M, v[15:8]);
    sw_read(HPS_HOST_WORD_L, v[7:0]);
  endtask
  // count drive cycles at two levels, brake cycles and others
  task automatic watch(input logic [6:0] a1, input logic [6:0] a2,
    input logic g2);
    bit seen;
    seen = 1'b0;
    n1 = 0;
    n2 = 0;
    nb = 0;
    no = 0;
    for (int i = 0; i < 600; i++)
    begin
      @(posedge mclk_i);
      #1;
      if (busy_o === 1'b1) seen = 1'b1;
      if (drive_en_o === 1'b1 && drive_amp_o === a1 && !drive_neg_o) n1++;
      else if (drive_en_o === 1'b1 && drive_amp_o === a2 &&
        drive_neg_o === g2) n2++;
      else if (drive_en_o === 1'b1) no++;
      if (brake_o === 1'b1) nb++;
      if (seen && busy_o === 1'b0) break;
    end
    // still running at the limit counts as a hang
    if (busy_o !== 1'b0) fail_count++;
  endtask

  initial
  begin
    repeat (8) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    sw_write(HPS_HOST_START, ST);
    sw_write(HPS_HOST_CMD, 8'h08);
    wait_idle();
    // corner pointers, the start location with its sign set, then random
    for (int i = 0; i < 12; i++)
    begin
      seed = xs(seed);
      ptrs[i] = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : seed[31:24];
      if (i == 2) ptrs[i] = ST;
      w = (i == 2) ? (seed[23:0] | 24'h200000) : seed[23:0];
      put_word(ptrs[i], w);
      mem[ptrs[i]] = stored(ptrs[i], w);
    end
    for (int i = 0; i < 12; i++)
    begin
      get_word(ptrs[i], w);
      check_val("word", mem[ptrs[i]], w);
    end
    sw_read(8'h7f, w[7:0]);
    check_val("unmapped", 24'h0, {16'h0, w[7:0]});
    sw_read(HPS_HOST_START, w[7:0]);
    check_val("start", {16'h0, ST}, {16'h0, w[7:0]});
    // more then last with brake; first sample repeated once
    put_word(ST, mk(HPS_LINK_MORE, 1'b0, 7'h55, 5'h02, 5'h01, 4'h1));
    put_word(ST + 8'h01, mk(HPS_LINK_LAST, 1'b1, 7'h2a, 5'h01, 5'h02,
      HPS_RPT_NONE));
    @(posedge mclk_i);
    trig_i <= 1'b1;
    watch(7'h55, 7'h2a, 1'b1);
    @(posedge mclk_i);
    trig_i <= 1'b0;
    check_range("drive_pos", 4 * S, 4 * S + 2, n1);
    check_range("drive_neg", S, S + 1, n2);
    check_range("brake", 2 * S, 2 * S + 1, nb);
    check_range("other", 0, 0, no);
    // whole pattern repeated twice more, host trigger command
    put_word(ST, mk(HPS_LINK_LOOP, 1'b0, 7'h7f, 5'h01, 5'h01, 4'h2));
    sw_write(HPS_HOST_CMD, 8'h04);
    watch(7'h7f, 7'h00, 1'b0);
    check_range("loop_drive", 3 * S, 3 * S + 3, n1);
    check_range("loop_brake", 0, 0, nb);
    // interpolation toward a zero sample halves the level
    put_word(ST, mk(HPS_LINK_INTERP, 1'b0, 7'h40, 5'h02, 5'h00,
      HPS_RPT_NONE));
    put_word(ST + 8'h01, mk(HPS_LINK_LAST, 1'b0, 7'h00, 5'h01, 5'h00,
      HPS_RPT_NONE));
    @(posedge mclk_i);
    trig_i <= 1'b1;
    watch(7'h40, 7'h20, 1'b0);
    @(posedge mclk_i);
    trig_i <= 1'b0;
    check_range("interp_start", 0, S + 1, n1);
    check_range("interp_half", 1, 2 * S + 1, n2);
    give_verdict();
  end
endmodule // tb_haptic_pattern_ram_store
